// >>> bench/sdram_module_command_timing_asserts.sv
// command pin timing checks between controller and memory module
`timescale 1ns/10ps
`default_nettype none
module sdram_module_command_timing_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic module_select_n,
    input wire logic clock_gate_enable,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic host_dq_oe,
    input wire logic [7:0] dev_dq_oe
);
    wire logic [2:0] cmd = {ras_n, cas_n, we_n};
    wire logic sel = !module_select_n;
    wire logic act = sel && cmd == sdram_pkg::CMD_ACTIVATE;
    wire logic mode = sel && cmd == sdram_pkg::CMD_MODE;
    wire logic pre = sel && cmd == sdram_pkg::CMD_PRECHARGE;
    wire logic rowc = act || mode || (sel && cmd == sdram_pkg::CMD_REFRESH);
    wire logic rd = sel && cmd == sdram_pkg::CMD_READ;
    wire logic wr = sel && cmd == sdram_pkg::CMD_WRITE;
    wire logic rw_any = rd || wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_row_quiet;
        (!rowc)[*8] ##1 !rowc;
    endsequence
    property p_row_gap; rowc |=> s_row_quiet; endproperty
    a_row_gap: assert property (p_row_gap) else $error("row commands too close");
    property p_act_rw; act |=> (!rw_any)[*6] ##1 rw_any; endproperty
    a_act_rw: assert property (p_act_rw) else $error("activate to column gap wrong");
    property p_act_pre; act |=> (!pre)[*6]; endproperty
    a_act_pre: assert property (p_act_pre) else $error("row closed too early");
    property p_pre_row; pre |=> (!rowc)[*3]; endproperty
    a_pre_row: assert property (p_pre_row) else $error("precharge recovery short");
    property p_act_act; act |=> (!act)[*2]; endproperty
    a_act_act: assert property (p_act_act) else $error("activates too close");
    property p_mode_row; mode |=> (!rowc)[*2]; endproperty
    a_mode_row: assert property (p_mode_row) else $error("mode recovery short");
    property p_wake; $rose(clock_gate_enable) |-> module_select_n[*2]; endproperty
    a_wake: assert property (p_wake) else $error("command too soon after wake");
    property p_wdata; wr |-> host_dq_oe && dev_dq_oe == 8'h00; endproperty
    a_wdata: assert property (p_wdata) else $error("write data not with command");
    property p_rdata; rd |-> ##[1:5] (|dev_dq_oe); endproperty
    a_rdata: assert property (p_rdata) else $error("read data missing");
    property p_wr_pre; host_dq_oe |-> !pre; endproperty
    a_wr_pre: assert property (p_wr_pre) else $error("precharge during write data");
    property p_wr_ap; $fell(host_dq_oe) |-> (!rowc)[*4]; endproperty
    a_wr_ap: assert property (p_wr_ap) else $error("write precharge recovery short");
    property p_rd_ap; $fell(|dev_dq_oe) |-> (!rowc)[*2]; endproperty
    a_rd_ap: assert property (p_rd_ap) else $error("read precharge recovery short");
    property p_rw_gap; rw_any |=> !sel; endproperty
    a_rw_gap: assert property (p_rw_gap) else $error("burst cut too soon");
endmodule
`default_nettype wire

// >>> bench/tb_sdram_module_command_timing.sv
// self-checking bench joining controller and memory module
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_module_command_timing;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_cl3 = 1'b0;
    logic [1:0] cfg_bl = 2'h0;
    logic cfg_interleave = 1'b0;
    logic req = 1'b0;
    logic req_we = 1'b0;
    logic [22:0] req_addr = 23'h000000;
    logic [63:0] wr_data = 64'h0;
    logic [7:0] wr_mask = 8'h00;
    logic sleep_req = 1'b0;
    logic req_taken, wr_take, rd_valid, asleep, self_refresh;
    logic [63:0] rd_data;
    logic [3:0] bank_open;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    sdram_if mem_bus ();
    sdram_host sdram_host_inst (.clk(clk), .rst(rst), .cfg_cl3(cfg_cl3), .cfg_bl(cfg_bl),
        .cfg_interleave(cfg_interleave), .req(req), .req_we(req_we), .req_addr(req_addr),
        .req_taken(req_taken), .wr_data(wr_data), .wr_mask(wr_mask), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .sleep_req(sleep_req), .asleep(asleep),
        .mem(mem_bus));
    sdram_dev sdram_dev_inst (.clk(clk), .rst(rst), .bank_open(bank_open),
        .self_refresh(self_refresh), .mem(mem_bus));
    sdram_module_command_timing_asserts sdram_module_command_timing_asserts_inst (.clk(clk),
        .rst(rst), .module_select_n(mem_bus.module_select_n),
        .clock_gate_enable(mem_bus.clock_gate_enable), .ras_n(mem_bus.ras_n),
        .cas_n(mem_bus.cas_n), .we_n(mem_bus.we_n), .host_dq_oe(mem_bus.host_dq_oe),
        .dev_dq_oe(mem_bus.dev_dq_oe));
    always #4 clk = ~clk;
    //----
    // tasks
    //----
    task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic issue(input logic we, input logic [22:0] a);
        req <= 1'b1;
        req_we <= we;
        req_addr <= a;
        do @(negedge clk); while (req_taken !== 1'b1);
        @(posedge clk);
        req <= 1'b0;
    endtask
    task automatic do_write(input logic [22:0] a, input logic [63:0] d, input logic [7:0] m,
                            input int n);
        wr_data <= d;
        wr_mask <= m;
        issue(1'b1, a);
        for (int i = 0; i < n; i++) begin
            do @(negedge clk); while (wr_take !== 1'b1);
            if (i == 0) begin
                chk64("bank_open", 64'h1, {63'h0, bank_open[a[22:21]]});
            end
            @(posedge clk);
            if (i + 1 < n) begin
                wr_data <= d + 64'(i + 1);
            end
        end
    endtask
    task automatic do_read(input logic [22:0] a, input logic [63:0] e, input int k, input int n);
        issue(1'b0, a);
        for (int i = 0; i < n; i++) begin
            do @(negedge clk); while (rd_valid !== 1'b1);
            chk64("rd_data", e + 64'(i ^ k), rd_data);
        end
        chk64("bank_open", 64'h0, {60'h0, bank_open});
        @(posedge clk);
    endtask
    //----
    // timeout
    //----
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    //----
    // tests
    //----
    initial begin
        do_reset();
        do_write(23'h000100, 64'h1122334455667788, 8'h00, 1);
        do_write(23'h000100, 64'hAABBCCDDEEFF0011, 8'h0F, 1);
        do_write(23'h7FFFFF, 64'hC0DEC0DE12345678, 8'h00, 1);
        do_read(23'h000100, 64'hAABBCCDD55667788, 0, 1);
        do_read(23'h7FFFFF, 64'hC0DEC0DE12345678, 0, 1);
        sleep_req <= 1'b1;
        do @(negedge clk); while (asleep !== 1'b1);
        @(negedge clk);
        chk64("self_refresh", 64'h1, {63'h0, self_refresh});
        @(posedge clk);
        sleep_req <= 1'b0;
        do_read(23'h000100, 64'hAABBCCDD55667788, 0, 1);
        chk64("self_refresh", 64'h0, {63'h0, self_refresh});
        cfg_cl3 <= 1'b1;
        cfg_bl <= 2'h2;
        cfg_interleave <= 1'b1;
        do_reset();
        do_write(23'h214A01, 64'h0F0F0F0F00000010, 8'h00, 4);
        do_read(23'h214A02, 64'h0F0F0F0F00000010, 3, 4);
        cfg_cl3 <= 1'b0;
        cfg_bl <= 2'h3;
        cfg_interleave <= 1'b0;
        do_reset();
        do_write(23'h4C0105, 64'h5A5A5A5A00000100, 8'h00, 8);
        do_read(23'h4C0101, 64'h5A5A5A5A00000100, 4, 8);
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> core/sdram_dev.sv
// memory module: eight byte-wide devices sharing command and address
`timescale 1ns/10ps
`default_nettype none
module sdram_dev (
    input wire logic clk,
    input wire logic rst,
    output logic [3:0] bank_open,
    output logic self_refresh,
    sdram_if.dev mem
);
    logic [63:0] store [0:sdram_pkg::DEPTH-1];
    logic [11:0] row_r [0:3];
    logic [3:0] open_r;
    logic cl3_r, ilv_r, sref_r, cke_q_r;
    logic [1:0] bl_r;
    logic rd_act_r, wr_act_r, ap_r;
    logic [1:0] bk_r;
    logic [8:0] col_r;
    logic [2:0] beat_r;
    logic [63:0] stage_a_r, stage_b_r, dout_r;
    logic va_r, vb_r;
    logic [7:0] m1_r, oe_r;
    logic sel, is_act, is_rd, is_wr, is_pre, is_mrs, is_rw, cut, go_rd, go_wr, last, vnext;
    logic [2:0] cmd, cur_beat;
    logic [1:0] ba, cur_bank;
    logic [8:0] cur_start, cur_col;
    logic [3:0] bl_len;
    logic [22:0] idx;
    //--------------------------------------------------
    // command decode
    //--------------------------------------------------
    assign ba = {mem.bank_select_hi, mem.bank_select_lo};
    assign cmd = {mem.ras_n, mem.cas_n, mem.we_n};
    assign sel = ~mem.module_select_n & mem.clock_gate_enable & ~sref_r;
    assign is_act = sel & (cmd == sdram_pkg::CMD_ACTIVATE);
    assign is_rd = sel & (cmd == sdram_pkg::CMD_READ);
    assign is_wr = sel & (cmd == sdram_pkg::CMD_WRITE);
    assign is_pre = sel & (cmd == sdram_pkg::CMD_PRECHARGE);
    assign is_mrs = sel & (cmd == sdram_pkg::CMD_MODE);
    assign is_rw = is_rd | is_wr;
    assign bl_len = 4'(4'h1 << bl_r);
    assign cut = is_pre & (mem.addr[sdram_pkg::AP_BIT] | (ba == bk_r));
    // a new read or write, or a precharge of the burst bank or of all banks, ends the burst in progress
    assign go_rd = is_rd | (rd_act_r & mem.clock_gate_enable & ~is_wr & ~cut);
    assign go_wr = is_wr | (wr_act_r & mem.clock_gate_enable & ~is_rd & ~cut);
    assign cur_bank = is_rw ? ba : bk_r;
    assign cur_start = is_rw ? mem.addr[8:0] : col_r;
    assign cur_beat = is_rw ? 3'h0 : beat_r;
    assign last = ({1'b0, cur_beat} == (bl_len - 4'h1));
    // burst address order, sequential or interleaved
    always_comb begin
        logic [8:0] m;
        logic [2:0] off;
        m = 9'((9'h1 << bl_r) - 9'h1);
        off = ilv_r ? (cur_start[2:0] ^ cur_beat) : 3'(cur_start[2:0] + cur_beat);
        cur_col = (cur_start & ~m) | ({6'h00, off} & m);
    end
    assign idx = {cur_bank, row_r[cur_bank], cur_col};
    //--------------------------------------------------
    // mode, power state
    //--------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cl3_r <= 1'b0;
            bl_r <= 2'h0;
            ilv_r <= 1'b0;
        end else if (is_mrs) begin
            bl_r <= mem.addr[sdram_pkg::MODE_BL_LSB+:2];
            ilv_r <= mem.addr[sdram_pkg::MODE_ILV_BIT];
            cl3_r <= (mem.addr[sdram_pkg::MODE_CL_LSB+:3] == sdram_pkg::MODE_CL3);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_q_r <= 1'b0;
            sref_r <= 1'b0;
        end else begin
            cke_q_r <= mem.clock_gate_enable;
            if (mem.clock_gate_enable) begin
                sref_r <= 1'b0;
            end else if (cke_q_r & ~mem.module_select_n & (cmd == sdram_pkg::CMD_REFRESH)) begin
                sref_r <= 1'b1;
            end
        end
    end
    //--------------------------------------------------
    // banks and burst tracking
    //--------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_r <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                row_r[b] <= 12'h000;
            end
        end else begin
            if ((go_rd | go_wr) & last & (is_rw ? mem.addr[sdram_pkg::AP_BIT] : ap_r)) begin
                open_r[cur_bank] <= 1'b0;
            end
            if (is_act) begin
                row_r[ba] <= mem.addr;
                open_r[ba] <= 1'b1;
            end else if (is_pre) begin
                if (mem.addr[sdram_pkg::AP_BIT]) begin
                    open_r <= 4'h0;
                end else begin
                    open_r[ba] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            ap_r <= 1'b0;
            bk_r <= 2'h0;
            col_r <= 9'h000;
            beat_r <= 3'h0;
        end else if (is_rw) begin
            rd_act_r <= is_rd & ~last;
            wr_act_r <= is_wr & ~last;
            ap_r <= mem.addr[sdram_pkg::AP_BIT];
            bk_r <= ba;
            col_r <= mem.addr[8:0];
            beat_r <= 3'h1;
        end else if (go_rd | go_wr) begin
            beat_r <= 3'(beat_r + 3'h1);
            if (last) begin
                rd_act_r <= 1'b0;
                wr_act_r <= 1'b0;
            end
        end else if (cut) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
        end
    end
    //--------------------------------------------------
    // write store and read pipeline
    //--------------------------------------------------
    always_ff @(posedge clk) begin
        for (int i = 0; i < sdram_pkg::LANES; i++) begin
            if (go_wr & ~mem.byte_lane_mask[i]) begin
                store[idx][8*i+:8] <= mem.dq[8*i+:8];
            end
        end
    end
    assign vnext = cl3_r ? vb_r : va_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_a_r <= 64'h0;
            stage_b_r <= 64'h0;
            dout_r <= 64'h0;
            va_r <= 1'b0;
            vb_r <= 1'b0;
            m1_r <= 8'h00;
            oe_r <= 8'h00;
        end else begin
            stage_a_r <= store[idx];
            va_r <= go_rd;
            stage_b_r <= stage_a_r;
            vb_r <= va_r;
            dout_r <= cl3_r ? stage_b_r : stage_a_r;
            m1_r <= mem.byte_lane_mask;
            oe_r <= {8{vnext}} & ~m1_r;
        end
    end
    assign mem.dev_dq = dout_r;
    assign mem.dev_dq_oe = oe_r;
    assign bank_open = open_r;
    assign self_refresh = sref_r;
endmodule
`default_nettype wire

// >>> core/sdram_host.sv
// memory controller: one access per activate, closed by autoprecharge
`timescale 1ns/10ps
`default_nettype none
module sdram_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_cl3,
    input wire logic [1:0] cfg_bl,
    input wire logic cfg_interleave,
    input wire logic req,
    input wire logic req_we,
    input wire logic [22:0] req_addr,
    output logic req_taken,
    input wire logic [63:0] wr_data,
    input wire logic [7:0] wr_mask,
    output logic wr_take,
    output logic [63:0] rd_data,
    output logic rd_valid,
    input wire logic sleep_req,
    output logic asleep,
    sdram_if.host mem
);
    sdram_pkg::host_state_t state_r, state_nxt;
    logic [3:0] wait_r, wait_nxt;
    logic [3:0] beat_r, beat_nxt;
    logic [3:0] rc_r;
    logic [10:0] ref_cnt_r;
    logic ref_due_r;
    logic cl3_r, ilv_r, we_hold_r;
    logic [1:0] bl_r;
    logic [22:0] addr_hold_r;
    logic [2:0] cmd_r, cmd_nxt;
    logic [11:0] a_r, a_nxt;
    logic [1:0] ba_r, ba_nxt;
    logic cke_r, cke_nxt;
    logic [7:0] dqm_r;
    logic [63:0] dq_r;
    logic dq_oe_r;
    logic rc_load, issue_ref, mode_issue, wdrive, cap;
    logic [3:0] bl_len, cl_cyc, apr_load;
    assign bl_len = 4'(4'h1 << bl_r);
    assign cl_cyc = cl3_r ? 4'h3 : 4'h2;
    // precharge time less (latency - 1), minus the issue and sample offsets
    assign apr_load = 4'(4'(sdram_pkg::T_RP_CYC - 1) - cl_cyc);
    //--------------------------------------------------
    // sequencer
    //--------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        wait_nxt = (wait_r != 4'h0) ? 4'(wait_r - 4'h1) : wait_r;
        beat_nxt = beat_r;
        cmd_nxt = sdram_pkg::CMD_NOP;
        a_nxt = 12'h000;
        ba_nxt = 2'h0;
        cke_nxt = 1'b1;
        rc_load = 1'b0;
        issue_ref = 1'b0;
        mode_issue = 1'b0;
        req_taken = 1'b0;
        wr_take = 1'b0;
        wdrive = 1'b0;
        cap = 1'b0;
        case (state_r)
            sdram_pkg::ST_BOOT: begin
                cmd_nxt = sdram_pkg::CMD_PRECHARGE;
                a_nxt[sdram_pkg::AP_BIT] = 1'b1;
                wait_nxt = 4'(sdram_pkg::T_RP_CYC - 1);
                state_nxt = sdram_pkg::ST_MODE;
            end
            sdram_pkg::ST_MODE: begin
                if (wait_r == 4'h0) begin
                    cmd_nxt = sdram_pkg::CMD_MODE;
                    a_nxt[sdram_pkg::MODE_BL_LSB+:3] = {1'b0, cfg_bl};
                    a_nxt[sdram_pkg::MODE_ILV_BIT] = cfg_interleave;
                    a_nxt[sdram_pkg::MODE_CL_LSB+:3] = cfg_cl3 ? sdram_pkg::MODE_CL3 :
                                                       sdram_pkg::MODE_CL2;
                    mode_issue = 1'b1;
                    rc_load = 1'b1;
                    wait_nxt = 4'(sdram_pkg::T_RSA_CYC - 1);
                    state_nxt = sdram_pkg::ST_REC;
                end
            end
            sdram_pkg::ST_IDLE: begin
                // row commands wait out the row cycle time
                if (rc_r == 4'h0) begin
                    if (ref_due_r) begin
                        cmd_nxt = sdram_pkg::CMD_REFRESH;
                        rc_load = 1'b1;
                        issue_ref = 1'b1;
                    end else if (sleep_req) begin
                        cmd_nxt = sdram_pkg::CMD_REFRESH;
                        cke_nxt = 1'b0;
                        rc_load = 1'b1;
                        issue_ref = 1'b1;
                        state_nxt = sdram_pkg::ST_SLEEP;
                    end else if (req) begin
                        cmd_nxt = sdram_pkg::CMD_ACTIVATE;
                        a_nxt = req_addr[20:9];
                        ba_nxt = req_addr[22:21];
                        req_taken = 1'b1;
                        rc_load = 1'b1;
                        wait_nxt = 4'(sdram_pkg::T_ACT_RW_CYC - 1);
                        state_nxt = sdram_pkg::ST_ACT;
                    end
                end
            end
            sdram_pkg::ST_ACT: begin
                if (wait_r == 4'h0) begin
                    cmd_nxt = we_hold_r ? sdram_pkg::CMD_WRITE : sdram_pkg::CMD_READ;
                    a_nxt[8:0] = addr_hold_r[8:0];
                    a_nxt[sdram_pkg::AP_BIT] = 1'b1;
                    ba_nxt = addr_hold_r[22:21];
                    if (we_hold_r) begin
                        wr_take = 1'b1;
                        wdrive = 1'b1;
                        beat_nxt = 4'h1;
                        state_nxt = sdram_pkg::ST_WBEAT;
                    end else begin
                        wait_nxt = cl_cyc;
                        beat_nxt = 4'h0;
                        state_nxt = sdram_pkg::ST_RWAIT;
                    end
                end
            end
            sdram_pkg::ST_WBEAT: begin
                // whole burst, never interrupted
                if (beat_r < bl_len) begin
                    wr_take = 1'b1;
                    wdrive = 1'b1;
                    beat_nxt = 4'(beat_r + 4'h1);
                end else begin
                    wait_nxt = 4'(sdram_pkg::T_APW_CYC - 2);
                    state_nxt = sdram_pkg::ST_REC;
                end
            end
            sdram_pkg::ST_RWAIT: begin
                if (wait_r == 4'h0) begin
                    cap = 1'b1;
                    beat_nxt = 4'(beat_r + 4'h1);
                    if (beat_r == 4'(bl_len - 4'h1)) begin
                        wait_nxt = apr_load;
                        state_nxt = sdram_pkg::ST_REC;
                    end
                end
            end
            sdram_pkg::ST_REC: begin
                if (wait_r == 4'h0) begin
                    state_nxt = sdram_pkg::ST_IDLE;
                end
            end
            sdram_pkg::ST_SLEEP: begin
                cke_nxt = 1'b0;
                if (!sleep_req) begin
                    cke_nxt = 1'b1;
                    wait_nxt = 4'(sdram_pkg::T_WAKE_CYC - 1);
                    state_nxt = sdram_pkg::ST_REC;
                end
            end
            default: begin
                state_nxt = sdram_pkg::ST_BOOT;
            end
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= sdram_pkg::ST_BOOT;
            wait_r <= 4'h0;
            beat_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            beat_r <= beat_nxt;
        end
    end
    //--------------------------------------------------
    // row cycle and refresh timers
    //--------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_r <= 4'h0;
        end else if (rc_load) begin
            rc_r <= 4'(sdram_pkg::T_RC_CYC - 1);
        end else if (rc_r != 4'h0) begin
            rc_r <= 4'(rc_r - 4'h1);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt_r <= 11'(sdram_pkg::T_REFI_CYC - 1);
            ref_due_r <= 1'b0;
        end else begin
            ref_due_r <= (ref_cnt_r == 11'h000) | (ref_due_r & ~issue_ref);
            if (ref_cnt_r == 11'h000) begin
                ref_cnt_r <= 11'(sdram_pkg::T_REFI_CYC - 1);
            end else begin
                ref_cnt_r <= 11'(ref_cnt_r - 11'h001);
            end
        end
    end
    //--------------------------------------------------
    // pins
    //--------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r <= sdram_pkg::CMD_NOP;
            a_r <= 12'h000;
            ba_r <= 2'h0;
            cke_r <= 1'b1;
            dqm_r <= 8'h00;
            dq_r <= 64'h0;
            dq_oe_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            a_r <= a_nxt;
            ba_r <= ba_nxt;
            cke_r <= cke_nxt;
            dqm_r <= wdrive ? wr_mask : 8'h00;
            dq_oe_r <= wdrive;
            if (wdrive) begin
                dq_r <= wr_data;
            end
        end
    end
    assign mem.module_select_n = (cmd_r == sdram_pkg::CMD_NOP);
    assign mem.clock_gate_enable = cke_r;
    assign mem.ras_n = cmd_r[2];
    assign mem.cas_n = cmd_r[1];
    assign mem.we_n = cmd_r[0];
    assign mem.addr = a_r;
    assign mem.bank_select_lo = ba_r[0];
    assign mem.bank_select_hi = ba_r[1];
    assign mem.byte_lane_mask = dqm_r;
    assign mem.host_dq = dq_r;
    assign mem.host_dq_oe = dq_oe_r;
    //--------------------------------------------------
    // user side
    //--------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cl3_r <= 1'b0;
            bl_r <= 2'h0;
            ilv_r <= 1'b0;
            addr_hold_r <= 23'h0;
            we_hold_r <= 1'b0;
            rd_data <= 64'h0;
            rd_valid <= 1'b0;
        end else begin
            if (mode_issue) begin
                cl3_r <= cfg_cl3;
                bl_r <= cfg_bl;
                ilv_r <= cfg_interleave;
            end
            if (req_taken) begin
                addr_hold_r <= req_addr;
                we_hold_r <= req_we;
            end
            rd_valid <= cap;
            if (cap) begin
                rd_data <= mem.dq;
            end
        end
    end
    assign asleep = (state_r == sdram_pkg::ST_SLEEP);
endmodule
`default_nettype wire

// >>> pkg/sdram_if.sv
// pin bundle between the memory module and its controller
`timescale 1ns/10ps
`default_nettype none
interface sdram_if;
    logic module_select_n;
    logic clock_gate_enable;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_lo;
    logic bank_select_hi;
    logic [11:0] addr;
    logic [7:0] byte_lane_mask;
    logic [63:0] host_dq;
    logic host_dq_oe;
    logic [63:0] dev_dq;
    logic [7:0] dev_dq_oe;
    logic [63:0] dq;
    //--------------------------------------------------
    // shared data wire per lane
    //--------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_lane
        assign dq[8*i+:8] = dev_dq_oe[i] ? dev_dq[8*i+:8] :
                            (host_dq_oe ? host_dq[8*i+:8] : 8'h00);
    end
    modport host (
        output module_select_n, clock_gate_enable, ras_n, cas_n, we_n,
        output bank_select_lo, bank_select_hi, addr, byte_lane_mask,
        output host_dq, host_dq_oe,
        input dq
    );
    modport dev (
        input module_select_n, clock_gate_enable, ras_n, cas_n, we_n,
        input bank_select_lo, bank_select_hi, addr, byte_lane_mask,
        output dev_dq, dev_dq_oe,
        input dq
    );
endinterface
`default_nettype wire

// >>> pkg/sdram_pkg.sv
// shared constants for the sdram module and its controller
//--------------------------------------------------
// Function
// - 8388608 words of 64 bits, eight lanes
// - read latency programmable to 2 or 3
// - burst length 1, 2, 4 or 8
// - four banks, each with own open row
// - interleaved order; later command cuts burst
// - activate to precharge 50 ns to 100000 ns
// - 80 ns between activate, mode, refresh commands
// - 30 ns from activate to read/write
// - precharge time before activate, mode, refresh
// - delay between activates in different banks
// - delay after mode set before row commands
// - read autoprecharge: precharge time less latency-1
// - write autoprecharge: precharge time plus one
// - 10 ns after clock enable rises
// - no interrupt sooner than one cycle
// - write data taken with write command
// - one cycle from last write data to precharge
// - read mask acts two cycles later
//--------------------------------------------------
package sdram_pkg;
    localparam int DATA_W = 64;
    localparam int LANES = 8;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int ADDR_W = 23;
    localparam int DEPTH = 8388608;
    localparam int CLK_PERIOD_PS = 8000;
    // command codes on ras_n, cas_n, we_n
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // mode word and address fields
    localparam int AP_BIT = 10;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_ILV_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] MODE_CL2 = 3'h2;
    localparam logic [2:0] MODE_CL3 = 3'h3;
    // timing
    localparam int T_RAS_MIN_NS = 50;
    localparam int T_RAS_MAX_NS = 100000;
    localparam int T_RC_NS = 80;
    localparam int T_RCD_NS = 30;
    localparam int T_RP_NS = 30;
    localparam int T_RRD_NS = 20;
    localparam int T_CESP_NS = 10;
    localparam int T_REFI_NS = 15600;
    localparam int T_RSA_CYC = 2;
    localparam int T_RAS_MIN_CYC = (T_RAS_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RC_CYC = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RCD_CYC = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RRD_CYC = (T_RRD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_CESP_CYC = (T_CESP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_REFI_CYC = T_REFI_NS * 1000 / CLK_PERIOD_PS;
    localparam int T_APW_CYC = T_RP_CYC + 1;
    localparam int T_ACT_RW_CYC = (T_RAS_MIN_CYC > T_RCD_CYC) ? T_RAS_MIN_CYC : T_RCD_CYC;
    localparam int T_WAKE_CYC = (T_RC_CYC > T_CESP_CYC) ? T_RC_CYC : T_CESP_CYC;
    typedef enum logic [3:0] {
        ST_BOOT = 4'h0,
        ST_MODE = 4'h1,
        ST_IDLE = 4'h3,
        ST_ACT = 4'h2,
        ST_RWAIT = 4'h6,
        ST_WBEAT = 4'h7,
        ST_REC = 4'h5,
        ST_SLEEP = 4'h4
    } host_state_t;
endpackage
